// ### src/pos_defines.svh
`ifndef POS_DEFINES_SVH
`define POS_DEFINES_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define POS_OFF_SPHASE  12'h000
`define POS_OFF_IOCTL   12'h004
`define POS_OFF_CHCTL   12'h008
`define POS_OFF_FLTCTL  12'h00C
`define POS_OFF_STATUS  12'h010
// ----------------------------------------------------------------
// Field positions in the I/O control register
// ----------------------------------------------------------------
`define POS_IO_HIGH_SIDE_POLARITY     13
`define POS_IO_POLL     12
`define POS_IO_MODE_HI  11
`define POS_IO_MODE_LO  10
`define POS_IO_OVREN_H  9
`define POS_IO_OVREN_L  8
`define POS_IO_OVRD_H   7
`define POS_IO_OVRD_L   6
`define POS_IO_CLD_H    3
`define POS_IO_CLD_L    2
`define POS_IO_SWAP     1
`define POS_IO_OVERRIDE_SYNC    0
// ----------------------------------------------------------------
// Field positions in channel and fault control registers
// ----------------------------------------------------------------
`define POS_CH_TBEN     15
`define POS_CH_ITB      9
`define POS_CH_CLK_HI   2
`define POS_CH_CLK_LO   0
`define POS_FLT_IFLT    15
`define POS_FLT_CURRENT_LIMIT_MODE_EN  8
// ----------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------
`define POS_RST_SPHASE  16'h0000
`define POS_RST_IOCTL   16'h0000
`define POS_RST_CHCTL   16'h0000
`define POS_RST_FLTCTL  16'h0000
`define POS_RESP_OKAY   2'h0
`define POS_RESP_SLVERR 2'h2
`endif

// ### src/pos_pkg.sv
package pos_pkg;
  // Output mode selection, in field order 00..11
  typedef enum logic [1:0] {
    POS_MODE_COMPL,
    POS_MODE_REDUND,
    POS_MODE_PUSHPULL,
    POS_MODE_INDEP
  } pos_mode_t;
  // What the secondary phase value is used for
  typedef enum logic [1:0] {
    POS_USE_NONE,
    POS_USE_SHIFT,
    POS_USE_PERIOD
  } pos_use_t;
endpackage

// ### src/pos_stage_if.sv
// ----------------------------------------------------------------
// Carrier between register block and output stage
// ----------------------------------------------------------------
interface pos_stage_if;
  logic       gen_high;    // Generator high-side signal
  logic       gen_low;     // Generator low-side signal
  logic       tb_boundary; // PWM time base boundary pulse
  logic       cl_active;   // Current limit in force (gated)
  logic [1:0] cl_data;     // Current-limit states {high, low}
  logic [1:0] ovr_en;      // Override enables {high, low}
  logic [1:0] ovr_data;    // Override states {high, low}
  logic       pol_high;    // High-side polarity, 1 = active low
  logic       pol_low;     // Low-side polarity, 1 = active low
  logic       swap;        // Exchange pins
  logic       override_sync;       // Override aligned to time base
  logic       pin_high;    // High pin level
  logic       pin_low;     // Low pin level
  modport ctrl  (output gen_high, gen_low, tb_boundary, cl_active,
                 cl_data, ovr_en, ovr_data, pol_high, pol_low, swap,
                 override_sync, input pin_high, pin_low);
  modport stage (input gen_high, gen_low, tb_boundary, cl_active,
                 cl_data, ovr_en, ovr_data, pol_high, pol_low, swap,
                 override_sync, output pin_high, pin_low);
endinterface

// ### src/pos_output_stage.sv
module pos_output_stage (
  input wire logic sys_clk,
  input wire logic rst_n,
  pos_stage_if.stage st
);
  // ----------------------------------------------------------------
  // Override latch
  // ----------------------------------------------------------------
  logic [1:0] ovr_en_reg;   // Applied override enables
  logic [1:0] ovr_data_reg; // Applied override states
  logic       act_high;     // Active state, high-side signal
  logic       act_low;      // Active state, low-side signal
  logic       lvl_high;     // Level after polarity, high signal
  logic       lvl_low;      // Level after polarity, low signal
  logic       pin_high_reg; // Registered high pin
  logic       pin_low_reg;  // Registered low pin

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ovr_en_reg   <= 2'h0;
      ovr_data_reg <= 2'h0;
    end else if (!st.override_sync || st.tb_boundary) begin
      // Free-running takes every clock, synced waits for boundary
      ovr_en_reg   <= st.ovr_en;
      ovr_data_reg <= st.ovr_data;
    end
  end

  // ----------------------------------------------------------------
  // Signal selection and polarity
  // ----------------------------------------------------------------
  // current-limit states drive pins
  always_comb begin
    if (st.cl_active) begin
      act_high = st.cl_data[1];
      act_low  = st.cl_data[0];
    end else begin
      act_high = ovr_en_reg[1] ? ovr_data_reg[1] : st.gen_high;
      act_low  = ovr_en_reg[0] ? ovr_data_reg[0] : st.gen_low;
    end
  end

  assign lvl_high = act_high ^ st.pol_high;
  assign lvl_low  = act_low ^ st.pol_low;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pin_high_reg <= 1'b0;
      pin_low_reg  <= 1'b0;
    end else begin
      pin_high_reg <= st.swap ? lvl_low : lvl_high;
      pin_low_reg  <= st.swap ? lvl_high : lvl_low;
    end
  end

  assign st.pin_high = pin_high_reg;
  assign st.pin_low  = pin_low_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_cl_high_drive: assert property (
    st.cl_active && !st.swap |=>
      st.pin_high == ($past(st.cl_data[1]) ^ $past(st.pol_high)))
    else $error("High pin not from current-limit state");
  chk_swap_route: assert property (
    st.swap && st.cl_active |=>
      st.pin_low == ($past(st.cl_data[1]) ^ $past(st.pol_high)))
    else $error("Swapped low pin not from high signal");
  chk_no_swap_low: assert property (
    !st.swap && !st.cl_active && ovr_en_reg[0] |=>
      st.pin_low == ($past(ovr_data_reg[0]) ^ $past(st.pol_low)))
    else $error("Low pin wrong after override and polarity");
  chk_override_sync_hold: assert property (
    st.override_sync && !st.tb_boundary |=> $stable(ovr_data_reg))
    else $error("Synced override changed off boundary");
  chk_override_sync_free: assert property (
    !st.override_sync |=> ovr_data_reg == $past(st.ovr_data))
    else $error("Free override not taken next clock");
  cov_swap_cl: cover property (st.swap && st.cl_active);
  cov_sync_ovr: cover property (st.override_sync && st.tb_boundary);
endmodule

// ### src/pwm_output_stage_control.sv
`include "pos_defines.svh"
module pwm_output_stage_control (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output wire logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output wire logic        s_axi_wready,
  output wire logic [1:0]  s_axi_bresp,
  output wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output wire logic        s_axi_arready,
  output wire logic [31:0] s_axi_rdata,
  output wire logic [1:0]  s_axi_rresp,
  output wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        gen_high,
  input  wire logic        gen_low,
  input  wire logic        tb_boundary,
  input  wire logic        current_limit_in,
  output wire logic        pwm_high_pin,
  output wire logic        pwm_low_pin,
  output wire logic [15:0] low_phase_shift,
  output wire logic        low_phase_shift_en,
  output wire logic [15:0] low_period,
  output wire logic        low_period_en,
  output wire logic        pwm_timebase_enable,
  output wire logic [2:0]  pwm_clock_sel
);
  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [15:0] secondary_phase_value_reg; // Secondary phase
  logic [15:0] pwm_io_control_reg;        // I/O control
  logic [15:0] pwm_channel_control_reg;   // Channel control
  logic [15:0] fault_limit_control_reg;   // Fault/limit control
  logic        cl_meta_reg;               // Limit synchroniser 1
  logic        cl_sync_reg;               // Limit synchroniser 2
  logic [15:0] shift_reg;                 // Phase shift output
  logic [15:0] period_reg;                // Period output
  pos_pkg::pos_use_t use_reg;             // Current use of phase

  // ----------------------------------------------------------------
  // Bus slave state
  // ----------------------------------------------------------------
  logic        aw_got_reg;  // Write address held
  logic [11:0] aw_addr_reg; // Held write address
  logic        w_got_reg;   // Write data held
  logic [31:0] w_data_reg;  // Held write data
  logic [3:0]  w_strb_reg;  // Held byte strobes
  logic        bvalid_reg;  // Write response pending
  logic [1:0]  bresp_reg;   // Write response code
  logic        rvalid_reg;  // Read data pending
  logic [31:0] rdata_reg;   // Read data
  logic [1:0]  rresp_reg;   // Read response code
  logic        wr_fire;     // Write performed this cycle

  // Decoded fields
  pos_pkg::pos_mode_t mode;   // Output mode selection
  logic               independent_time_base_sel;    // Independent time base selection
  logic               iflt;   // Independent fault mode
  logic               current_limit_mode_en; // Current-limit mode enable
  logic               cl_on;  // Limit in force after gating
  pos_pkg::pos_use_t  use_next;

  pos_stage_if st_if ();

  // Merge one 16-bit register with strobed write data
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  stb);
    merge16 = {stb[1] ? dat[15:8] : old[15:8],
               stb[0] ? dat[7:0] : old[7:0]};
  endfunction

  // Map an address to a known register
  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a == `POS_OFF_SPHASE) || (a == `POS_OFF_IOCTL) ||
                 (a == `POS_OFF_CHCTL) || (a == `POS_OFF_FLTCTL) ||
                 (a == `POS_OFF_STATUS);
  endfunction

  // ----------------------------------------------------------------
  // Write channels
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_got_reg;
  assign s_axi_wready  = !w_got_reg;
  assign wr_fire       = aw_got_reg && w_got_reg && !bvalid_reg;

  // Capture address and data in either order
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      aw_got_reg  <= 1'b0;
      aw_addr_reg <= 12'h000;
    end else if (s_axi_awvalid && !aw_got_reg) begin
      aw_got_reg  <= 1'b1;
      aw_addr_reg <= {s_axi_awaddr[11:2], 2'h0};
    end else if (wr_fire) begin
      aw_got_reg  <= 1'b0;
    end
  end

  // Capture write data and strobes
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      w_got_reg  <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && !w_got_reg) begin
      w_got_reg  <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_got_reg  <= 1'b0;
    end
  end

  // Write response, error for unknown or read-only offsets
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `POS_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (addr_known(aw_addr_reg) &&
                     aw_addr_reg != `POS_OFF_STATUS) ?
                    `POS_RESP_OKAY : `POS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  // ----------------------------------------------------------------
  // Register updates
  // ----------------------------------------------------------------
  // Each store merges the strobed bytes into its old value

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      secondary_phase_value_reg <= `POS_RST_SPHASE;
    end else if (wr_fire && aw_addr_reg == `POS_OFF_SPHASE) begin
      secondary_phase_value_reg <= merge16(secondary_phase_value_reg,
                                           w_data_reg, w_strb_reg);
    end
  end

  // I/O control storage
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pwm_io_control_reg <= `POS_RST_IOCTL;
    end else if (wr_fire && aw_addr_reg == `POS_OFF_IOCTL) begin
      pwm_io_control_reg <= merge16(pwm_io_control_reg,
                                    w_data_reg, w_strb_reg);
    end
  end

  // Channel control storage; clock select is left to software
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pwm_channel_control_reg <= `POS_RST_CHCTL;
    end else if (wr_fire && aw_addr_reg == `POS_OFF_CHCTL) begin
      pwm_channel_control_reg <= merge16(pwm_channel_control_reg,
                                         w_data_reg, w_strb_reg);
    end
  end

  // Fault and limit control storage
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fault_limit_control_reg <= `POS_RST_FLTCTL;
    end else if (wr_fire && aw_addr_reg == `POS_OFF_FLTCTL) begin
      fault_limit_control_reg <= merge16(fault_limit_control_reg,
                                         w_data_reg, w_strb_reg);
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = !rvalid_reg;

  // Registered read data, zero above bit 15
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= `POS_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= addr_known({s_axi_araddr[11:2], 2'h0}) ?
                    `POS_RESP_OKAY : `POS_RESP_SLVERR;
      unique case ({s_axi_araddr[11:2], 2'h0})
        `POS_OFF_SPHASE: rdata_reg <= {16'h0000,
                                       secondary_phase_value_reg};
        `POS_OFF_IOCTL:  rdata_reg <= {16'h0000, pwm_io_control_reg};
        `POS_OFF_CHCTL:  rdata_reg <= {16'h0000,
                                       pwm_channel_control_reg};
        `POS_OFF_FLTCTL: rdata_reg <= {16'h0000,
                                       fault_limit_control_reg};
        `POS_OFF_STATUS: rdata_reg <= {27'h0000000, use_reg, cl_on,
                                       st_if.pin_high, st_if.pin_low};
        default:         rdata_reg <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

  // ----------------------------------------------------------------
  // Current-limit input synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cl_meta_reg <= 1'b0;
      cl_sync_reg <= 1'b0;
    end else begin
      cl_meta_reg <= current_limit_in;
      cl_sync_reg <= cl_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  assign mode = pos_pkg::pos_mode_t'(
    pwm_io_control_reg[`POS_IO_MODE_HI:`POS_IO_MODE_LO]);
  assign independent_time_base_sel    = pwm_channel_control_reg[`POS_CH_ITB];
  assign iflt   = fault_limit_control_reg[`POS_FLT_IFLT];
  assign current_limit_mode_en = fault_limit_control_reg[`POS_FLT_CURRENT_LIMIT_MODE_EN];

  // independent fault mode drops limit states
  assign cl_on = cl_sync_reg && current_limit_mode_en && !iflt;

  always_comb begin
    use_next = pos_pkg::POS_USE_NONE;
    if (mode == pos_pkg::POS_MODE_INDEP) begin
      // shared time base gives a shift
      // own time base gives a period
      use_next = independent_time_base_sel ? pos_pkg::POS_USE_PERIOD : pos_pkg::POS_USE_SHIFT;
    end
  end

  // phase value reaches low side only
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      use_reg    <= pos_pkg::POS_USE_NONE;
      shift_reg  <= 16'h0000;
      period_reg <= 16'h0000;
    end else begin
      use_reg    <= use_next;
      shift_reg  <= (use_next == pos_pkg::POS_USE_SHIFT) ?
                    secondary_phase_value_reg : 16'h0000;
      period_reg <= (use_next == pos_pkg::POS_USE_PERIOD) ?
                    secondary_phase_value_reg : 16'h0000;
    end
  end

  assign low_phase_shift     = shift_reg;
  assign low_period          = period_reg;
  assign low_phase_shift_en  = (use_reg == pos_pkg::POS_USE_SHIFT);
  assign low_period_en       = (use_reg == pos_pkg::POS_USE_PERIOD);
  assign pwm_timebase_enable = pwm_channel_control_reg[`POS_CH_TBEN];
  assign pwm_clock_sel =
    pwm_channel_control_reg[`POS_CH_CLK_HI:`POS_CH_CLK_LO];

  // ----------------------------------------------------------------
  // Output stage connection
  // ----------------------------------------------------------------
  assign st_if.gen_high    = gen_high;
  assign st_if.gen_low     = gen_low;
  assign st_if.tb_boundary = tb_boundary;
  assign st_if.cl_active   = cl_on;
  assign st_if.cl_data     =
    pwm_io_control_reg[`POS_IO_CLD_H:`POS_IO_CLD_L];
  assign st_if.ovr_en      =
    pwm_io_control_reg[`POS_IO_OVREN_H:`POS_IO_OVREN_L];
  assign st_if.ovr_data    =
    pwm_io_control_reg[`POS_IO_OVRD_H:`POS_IO_OVRD_L];
  assign st_if.pol_high    = pwm_io_control_reg[`POS_IO_HIGH_SIDE_POLARITY];
  assign st_if.pol_low     = pwm_io_control_reg[`POS_IO_POLL];
  assign st_if.swap        = pwm_io_control_reg[`POS_IO_SWAP];
  assign st_if.override_sync       = pwm_io_control_reg[`POS_IO_OVERRIDE_SYNC];

  pos_output_stage u_stage (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .st      (st_if.stage)
  );

  assign pwm_high_pin = st_if.pin_high;
  assign pwm_low_pin  = st_if.pin_low;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_phase_unused: assert property (
    mode != pos_pkg::POS_MODE_INDEP |=>
      !low_phase_shift_en && !low_period_en && low_period == 16'h0000)
    else $error("Secondary phase used outside independent mode");
  chk_phase_shift: assert property (
    mode == pos_pkg::POS_MODE_INDEP && !independent_time_base_sel |=>
      low_phase_shift_en &&
      low_phase_shift == $past(secondary_phase_value_reg))
    else $error("Phase shift not taken from secondary phase");
  chk_phase_period: assert property (
    mode == pos_pkg::POS_MODE_INDEP && independent_time_base_sel |=>
      low_period_en && low_period == $past(secondary_phase_value_reg))
    else $error("Period not taken from secondary phase");
  chk_iflt_ignore: assert property (
    iflt |-> !cl_on)
    else $error("Limit states used in independent fault mode");
  chk_cl_gate: assert property (
    $past(current_limit_in, 2) && current_limit_mode_en && !iflt &&
      $stable(fault_limit_control_reg) |-> cl_on)
    else $error("Current limit not applied two clocks after pin");
  chk_polarity_cl: assert property (
    cl_on && !st_if.swap && $stable(pwm_io_control_reg) |=>
      pwm_high_pin == ($past(st_if.cl_data[1]) ^ $past(st_if.pol_high)))
    else $error("Limit state not mapped through polarity");
  chk_sphase_write: assert property (
    wr_fire && aw_addr_reg == `POS_OFF_SPHASE && w_strb_reg[1:0] == 2'h3
      |=> secondary_phase_value_reg == $past(w_data_reg[15:0]))
    else $error("Secondary phase write lost");
  chk_bresp_timing: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
      (!s_axi_bvalid || s_axi_bready) |-> ##2 s_axi_bvalid)
    else $error("Write response not two clocks after request");
  cov_write_phase: cover property (wr_fire &&
    aw_addr_reg == `POS_OFF_SPHASE);
  cov_period_use: cover property (low_period_en);
  cov_cl_active: cover property (cl_on);
endmodule

// ### tb/pos_power_stage.sv
// -------
// Power stage seen from the output pins
// -------
module pos_power_stage (
  input  wire logic pin_high,
  input  wire logic pin_low,
  input  wire logic trip,
  output wire logic current_limit_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Sense comparator: commanded overcurrent or shoot-through
  assign current_limit_in = trip | (pin_high & pin_low);
endmodule

// ### tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, h, l;
  logic s_axi_arvalid, s_axi_rready, gen_high, gen_low, tb_boundary, trip;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, sh, pe;
  logic s_axi_rvalid, current_limit_in, pwm_high_pin, pwm_low_pin;
  logic low_phase_shift_en, low_period_en, pwm_timebase_enable;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, lf;
  logic [15:0] low_phase_shift, low_period, v;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  pwm_clock_sel;
  logic [33:0] expq[$];
  int          err_total, check_count;
  pwm_output_stage_control DUT (.*);
  pos_power_stage pwr (.pin_high(pwm_high_pin), .pin_low(pwm_low_pin),
                       .trip(trip), .current_limit_in(current_limit_in));
  // Free-running 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(string n, logic [33:0] e, logic [33:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Bus write: offer address and data, release each when taken
  task automatic wr(logic [11:0] a, logic [15:0] d);
    int n;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (n = 0; n < 40 && !s_axi_bvalid; n++) begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk("bresp", 34'h0, {32'h0, s_axi_bresp});
    if (n == 40) begin
      err_total++;
      finish_test();
    end
  endtask
  // Bus read: the monitor compares the answer with the note
  task automatic rd(logic [11:0] a, logic [33:0] e);
    int n;
    expq.push_back(e);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (n = 0; n < 40 && !s_axi_rvalid; n++) begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    repeat (2) @(posedge sys_clk);
    if (n == 40) begin
      err_total++;
      finish_test();
    end
  endtask
  // Read monitor takes the oldest note for each answer
  always @(posedge sys_clk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      if (expq.size() > 0) begin
        chk("read", expq.pop_front(), {s_axi_rresp, s_axi_rdata});
      end else begin
        err_total++;
      end
    end
  end
  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, h, l} = 6'h00;
    {s_axi_arvalid, s_axi_rready, gen_high, gen_low, tb_boundary} = 5'h00;
    {trip, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 57'h0;
    s_axi_wstrb = 4'hF;
    lf = 32'h89C7;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(12'h000, 34'h000000000);
    rd(12'h014, {2'h2, 32'h0});
    $display("reset and map done");
    lf = nx(lf);
    v = lf[15:0];
    wr(12'h000, v);
    rd(12'h000, {18'h0, v});
    for (int k = 0; k < 8; k++) begin
      // clock select written while the time base is stopped
      wr(12'h008, {6'h00, k[0], 6'h00, lf[2:0]});
      wr(12'h004, {4'h0, k[2:1], 10'h000});
      repeat (2) @(posedge sys_clk);
      sh = (k[2:1] == 2'h3) && !k[0];
      pe = (k[2:1] == 2'h3) && k[0];
      chk("phase", {sh, sh ? v : 16'h0, pe, pe ? v : 16'h0},
          {low_phase_shift_en, low_phase_shift, low_period_en,
           low_period});
      chk("clksel", {31'h0, lf[2:0]},
          {30'h0, pwm_timebase_enable, pwm_clock_sel});
    end
    $display("phase use done");
    for (int k = 0; k < 8; k++) begin
      lf = nx(lf);
      gen_high <= lf[0];
      gen_low <= lf[1];
      h = lf[0] ^ k[2];
      l = lf[1] ^ k[1];
      wr(12'h004, {2'h0, k[2:1], 10'h000, k[0], 1'b0});
      rd(12'h010, {32'h0, k[0] ? {l, h} : {h, l}});
      chk("pins", {32'h0, k[0] ? {l, h} : {h, l}},
          {32'h0, pwm_high_pin, pwm_low_pin});
    end
    $display("polarity and swap done");
    gen_high <= 1'b0;
    gen_low <= 1'b0;
    wr(12'h004, 16'h0381);
    rd(12'h010, 34'h000000000);
    tb_boundary <= 1'b1;
    @(posedge sys_clk);
    tb_boundary <= 1'b0;
    rd(12'h010, 34'h000000002);
    wr(12'h004, 16'h0340);
    rd(12'h010, 34'h000000001);
    $display("override sync done");
    wr(12'h004, 16'h2308);
    wr(12'h00C, 16'h0100);
    trip <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(12'h010, 34'h000000004);
    wr(12'h00C, 16'h8100);
    rd(12'h010, 34'h000000002);
    $display("current limit done");
    if (expq.size() != 0) err_total++;
    finish_test();
  end
endmodule
